// ---- design/pdf_hi_pin_mux.v ----
// function decode and drive select for one pin of pins 20..16
// assumes mode levels already synchronised
`timescale 1ns/1ps
`default_nettype none
`include "pdf_map.vh"
module pdf_hi_pin_mux (
   input  wire [1:0] field,
   input  wire       single_chip,
   input  wire       rom_enable,
   input  wire       cs0_wide,
   input  wire       gpio_out,
   input  wire       gpio_oe,
   input  wire       bus_out,
   input  wire       bus_oe,
   output reg        sel_bus,
   output reg        sel_irq,
   output wire       drv_out,
   output wire       drv_oe
);
   always @*
   begin
      sel_bus = 1'b0;
      sel_irq = 1'b0;
      case (field)
         `PDF_CODE_GPIO: sel_bus = !single_chip && !rom_enable && cs0_wide;
         `PDF_CODE_BUS:  sel_bus = !single_chip;
         `PDF_CODE_IRQ:  sel_irq = 1'b1;
         `PDF_CODE_RSVD: sel_bus = 1'b0;
         default:        sel_bus = 1'b0;
      endcase
   end

   // interrupt input leaves the pad undriven
   assign drv_out = sel_bus ? bus_out : gpio_out;
   assign drv_oe  = sel_irq ? 1'b0 : (sel_bus ? bus_oe : gpio_oe);
endmodule // pdf_hi_pin_mux
`default_nettype wire

// ---- design/pdf_map.vh ----
// constants for the port d pin function select block
// assumes inclusion by bare name from the design files
// Notes on behaviour
// - bits 9:8 pick pin 20 as gpio (00), bus bit 20 (01), interrupt input 4 (10), 11 reserved.
// - bits 7:6 pick pin 19 as gpio (00), bus bit 19 (01), interrupt input 3 (10), 11 reserved.
// - bits 5:4 pick pin 18 as gpio (00), bus bit 18 (01), interrupt input 2 (10), 11 reserved.
// - bits 3:2 pick pin 17 as gpio (00), bus bit 17 (01), interrupt input 1 (10), 11 reserved.
// - bits 1:0 pick pin 16 as gpio (00), bus bit 16 (01), interrupt input 0 (10), 11 reserved.
// - code 00 is the reset default and means gpio, but bus bit when rom is off outside single chip mode and area 0 is 32 bit.
// - code 01 means bus bit, except in single chip mode where the pin stays gpio.
// - the low control register is 16 bits read/write and bit n sets the function of pin n.
// - a clear low bit means gpio, but the pin is a bus bit whenever rom is off outside single chip mode.
// - a set low bit means bus bit, except in single chip mode where it stays gpio.
// - with rom off outside single chip mode, in any bus width mode and package, all low pins are bus pins.
// - with rom on in an extended mode, each low pin follows its control bit.
// - in single chip mode all low pins are gpio whatever the register holds.
// - power-on reset clears the low control register to zero.
// - manual reset, watchdog reset, standby and sleep keep the register contents.
`ifndef PDF_MAP_VH
`define PDF_MAP_VH
`define PDF_MID_CTRL_OFS   8'h00
`define PDF_LOW_CTRL_OFS   8'h04
`define PDF_BUS_STAT_OFS   8'h08
`define PDF_HI_STAT_OFS    8'h0c
`define PDF_MODE_STAT_OFS  8'h10
`define PDF_MID_FIELD_W    10
`define PDF_LOW_CTRL_RST   16'h0000
`define PDF_MID_CTRL_RST   10'h000
`define PDF_CODE_GPIO      2'b00
`define PDF_CODE_BUS       2'b01
`define PDF_CODE_IRQ       2'b10
`define PDF_CODE_RSVD      2'b11
`define PDF_HI_IRQ_LSB     8
`define PDF_MODE_SINGLE    0
`define PDF_MODE_ROM_EN    1
`define PDF_MODE_CS0_WIDE  2
`define PDF_MODE_BUS_W     3
`define PDF_MODE_PKG_LARGE 4
`define PDF_MODE_BITS      5
`endif

// ---- design/pdf_sync2.v ----
// two-flop synchroniser for pad and strap levels
// assumes slowly changing levels; no pulse capture
`timescale 1ns/1ps
`default_nettype none
module pdf_sync2 #(
   parameter WIDTH = 1
) (
   input  wire             core_clk,
   input  wire             rst_n,
   input  wire [WIDTH-1:0] async_in,
   output reg  [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta_r;

   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_r   <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end
      else
      begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule // pdf_sync2
`default_nettype wire

// ---- design/pdf_top.v ----
// port d pin function select for pins 20..0 with its two control registers
// assumes pads, port gpio logic, bus controller and interrupt unit outside;
// rst_n is the external power-on reset only
`timescale 1ns/1ps
`default_nettype none
`include "pdf_map.vh"
module pdf_top #(
   parameter ADDR_W   = 8,
   parameter DATA_W   = 16,
   parameter LOW_PINS = 16,
   parameter HI_PINS  = 5
) (
   input  wire                        core_clk,
   input  wire                        rst_n,
   input  wire [ADDR_W-1:0]           reg_addr,
   input  wire [DATA_W-1:0]           reg_wdata,
   input  wire                        reg_wr,
   input  wire                        reg_rd,
   output reg  [DATA_W-1:0]           reg_rdata,
   input  wire                        mode_single_chip,
   input  wire                        mode_rom_enable,
   input  wire                        mode_cs0_wide,
   input  wire                        mode_bus_width,
   input  wire                        mode_pkg_large,
   input  wire [LOW_PINS+HI_PINS-1:0] pad_in,
   output reg  [LOW_PINS+HI_PINS-1:0] pad_out,
   output reg  [LOW_PINS+HI_PINS-1:0] pad_oe,
   input  wire [LOW_PINS+HI_PINS-1:0] gpio_out,
   input  wire [LOW_PINS+HI_PINS-1:0] gpio_oe,
   output reg  [LOW_PINS+HI_PINS-1:0] gpio_din,
   input  wire [LOW_PINS+HI_PINS-1:0] bus_dout,
   input  wire                        bus_doe,
   output reg  [LOW_PINS+HI_PINS-1:0] bus_din,
   output reg  [HI_PINS-1:0]          ext_int_req_n
);
   localparam NPINS = LOW_PINS + HI_PINS;
   localparam MID_W = `PDF_MID_FIELD_W;

   ////////////////////////////////////////////////////////////////////////////
   // synchronisers

   wire [NPINS-1:0]          pad_s;
   wire [`PDF_MODE_BITS-1:0] mode_raw;
   wire [`PDF_MODE_BITS-1:0] mode_s;
   wire                      single_s;
   wire                      rom_en_s;
   wire                      cs0_wide_s;

   assign mode_raw = {mode_pkg_large, mode_bus_width, mode_cs0_wide,
                      mode_rom_enable, mode_single_chip};

   pdf_sync2 #(
      .WIDTH    (NPINS)
   ) u_pad_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .async_in (pad_in),
      .sync_out (pad_s)
   );

   pdf_sync2 #(
      .WIDTH    (`PDF_MODE_BITS)
   ) u_mode_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .async_in (mode_raw),
      .sync_out (mode_s)
   );

   assign single_s   = mode_s[`PDF_MODE_SINGLE];
   assign rom_en_s   = mode_s[`PDF_MODE_ROM_EN];
   assign cs0_wide_s = mode_s[`PDF_MODE_CS0_WIDE];

   ////////////////////////////////////////////////////////////////////////////
   // control registers

   reg  [LOW_PINS-1:0] low_ctrl_r;
   reg  [MID_W-1:0]    mid_ctrl_r;
   wire                wr_low;
   wire                wr_mid;

   assign wr_low = reg_wr && (reg_addr == `PDF_LOW_CTRL_OFS);
   assign wr_mid = reg_wr && (reg_addr == `PDF_MID_CTRL_OFS);

   // only power-on reset clears; other resets and low power keep contents
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         low_ctrl_r <= `PDF_LOW_CTRL_RST;
         mid_ctrl_r <= `PDF_MID_CTRL_RST;
      end
      else
      begin
         if (wr_low)
         begin
            low_ctrl_r <= reg_wdata[LOW_PINS-1:0];
         end
         if (wr_mid)
         begin
            mid_ctrl_r <= reg_wdata[MID_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // low pins 15..0

   reg  [LOW_PINS-1:0] low_bus_sel;
   wire [LOW_PINS-1:0] low_drv_out;
   wire [LOW_PINS-1:0] low_drv_oe;

   always @*
   begin
      if (single_s)
      begin
         low_bus_sel = {LOW_PINS{1'b0}};
      end
      else if (!rom_en_s)
      begin
         low_bus_sel = {LOW_PINS{1'b1}};
      end
      else
      begin
         low_bus_sel = low_ctrl_r;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < LOW_PINS; gi = gi + 1)
      begin : g_low
         assign low_drv_out[gi] = low_bus_sel[gi] ? bus_dout[gi] : gpio_out[gi];
         assign low_drv_oe[gi]  = low_bus_sel[gi] ? bus_doe : gpio_oe[gi];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // high pins 20..16

   wire [HI_PINS-1:0] hi_bus_sel;
   wire [HI_PINS-1:0] hi_irq_sel;
   wire [HI_PINS-1:0] hi_drv_out;
   wire [HI_PINS-1:0] hi_drv_oe;

   // field i sits at bits 2i+1:2i and serves pin 16+i
   generate
      for (gi = 0; gi < HI_PINS; gi = gi + 1)
      begin : g_hi
         pdf_hi_pin_mux u_mux (
            .field       (mid_ctrl_r[2*gi+1:2*gi]),
            .single_chip (single_s),
            .rom_enable  (rom_en_s),
            .cs0_wide    (cs0_wide_s),
            .gpio_out    (gpio_out[LOW_PINS+gi]),
            .gpio_oe     (gpio_oe[LOW_PINS+gi]),
            .bus_out     (bus_dout[LOW_PINS+gi]),
            .bus_oe      (bus_doe),
            .sel_bus     (hi_bus_sel[gi]),
            .sel_irq     (hi_irq_sel[gi]),
            .drv_out     (hi_drv_out[gi]),
            .drv_oe      (hi_drv_oe[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // registered pad drive and inward paths

   wire [NPINS-1:0] pin_bus_sel;
   wire [HI_PINS-1:0] irq_nxt;

   assign pin_bus_sel = {hi_bus_sel, low_bus_sel};
   // unselected interrupt inputs rest inactive high; reserved code links none
   assign irq_nxt = ~hi_irq_sel | pad_s[NPINS-1:LOW_PINS];

   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pad_out       <= {NPINS{1'b0}};
         pad_oe        <= {NPINS{1'b0}};
         gpio_din      <= {NPINS{1'b0}};
         bus_din       <= {NPINS{1'b0}};
         ext_int_req_n <= {HI_PINS{1'b1}};
      end
      else
      begin
         pad_out       <= {hi_drv_out, low_drv_out};
         pad_oe        <= {hi_drv_oe, low_drv_oe};
         gpio_din      <= pad_s;
         bus_din       <= pad_s & pin_bus_sel;
         ext_int_req_n <= irq_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register read port

   reg [DATA_W-1:0] rdata_nxt;

   always @*
   begin
      rdata_nxt = {DATA_W{1'b0}};
      if (reg_rd)
      begin
         case (reg_addr)
            `PDF_MID_CTRL_OFS:
               rdata_nxt[MID_W-1:0] = mid_ctrl_r;
            `PDF_LOW_CTRL_OFS:
               rdata_nxt[LOW_PINS-1:0] = low_ctrl_r;
            `PDF_BUS_STAT_OFS:
               rdata_nxt[LOW_PINS-1:0] = low_bus_sel;
            `PDF_HI_STAT_OFS:
            begin
               rdata_nxt[HI_PINS-1:0] = hi_bus_sel;
               rdata_nxt[`PDF_HI_IRQ_LSB+HI_PINS-1:`PDF_HI_IRQ_LSB] = hi_irq_sel;
            end
            `PDF_MODE_STAT_OFS:
               rdata_nxt[`PDF_MODE_BITS-1:0] = mode_s;
            default:
               rdata_nxt = {DATA_W{1'b0}};
         endcase
      end
   end

   // read data stands only in the cycle after the strobe
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reg_rdata <= {DATA_W{1'b0}};
      end
      else
      begin
         reg_rdata <= rdata_nxt;
      end
   end
endmodule // pdf_top
`default_nettype wire

// ---- test/pdf_checker.sv ----
// port-level assertions for the pin function select top
// assumes binding onto pdf_top, single clock domain
`timescale 1ns/1ps
`default_nettype none
module pdf_checker (
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire logic [7:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic        mode_single_chip,
   input wire logic        mode_rom_enable,
   input wire logic [20:0] pad_in,
   input wire logic [20:0] pad_out,
   input wire logic [20:0] pad_oe,
   input wire logic [20:0] gpio_out,
   input wire logic [20:0] gpio_oe,
   input wire logic        bus_doe,
   input wire logic [20:0] bus_din,
   input wire logic [4:0]  ext_int_req_n
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data outside read slot");
   chk_low_echo: assert property (reg_wr && reg_addr == 8'h04 ##1 reg_rd && reg_addr == 8'h04
      |=> reg_rdata == $past(reg_wdata, 2)) else $error("low control read back wrong");
   // rst_n in the window keeps attempts off the edge that still resets the synchronisers
   chk_single_low: assert property ((mode_single_chip && rst_n)[*4]
      |-> pad_oe[15:0] == $past(gpio_oe[15:0]) && pad_out[15:0] == $past(gpio_out[15:0]))
      else $error("single chip low pin not gpio");
   chk_single_din: assert property ((mode_single_chip && rst_n)[*4]
      |-> bus_din == 21'h000000) else $error("bus input active in single chip");
   chk_romoff_drive: assert property ((!mode_single_chip && !mode_rom_enable && rst_n)[*4]
      |-> pad_oe[15:0] == {16{$past(bus_doe)}}) else $error("rom off low pin not bus");
   chk_romoff_din: assert property ((!mode_single_chip && !mode_rom_enable && rst_n)[*4]
      |-> bus_din[15:0] == $past(pad_in[15:0], 3)) else $error("rom off bus input wrong");
   chk_irq_input: assert property ((~ext_int_req_n & pad_oe[20:16]) == 5'h00)
      else $error("interrupt pin driven");
   chk_irq_level: assert property ((~ext_int_req_n & $past(pad_in[20:16], 3)) == 5'h00)
      else $error("interrupt request without low pad");
   cover property (reg_wr && reg_addr == 8'h00);
   cover property (mode_single_chip[*4]);
   cover property (ext_int_req_n != 5'h1f);
endmodule // pdf_checker
bind pdf_top pdf_checker i_chk (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .mode_single_chip, .mode_rom_enable, .pad_in, .pad_out, .pad_oe, .gpio_out,
   .gpio_oe, .bus_doe, .bus_din, .ext_int_req_n);
`default_nettype wire

// ---- test/pdf_far_model.sv ----
// far side of the pads: external bus and interrupt sources
// assumes ext_lvl is what the outside world drives
`timescale 1ns/1ps
`default_nettype none
module pdf_far_model (
   input  wire logic [20:0] pad_out,
   input  wire logic [20:0] pad_oe,
   input  wire logic [20:0] ext_lvl,
   output var  logic [20:0] pad_in
);
   // a driven pad reads back our drive
   always_comb pad_in = (pad_oe & pad_out) | (~pad_oe & ext_lvl);
endmodule // pdf_far_model
`default_nettype wire

// ---- test/port_d_pin_function_select_tb_top.sv ----
// self-checking bench for the pin function select top
// assumes pdf_top, pdf_far_model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module port_d_pin_function_select_tb_top;
   logic        core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, bus_doe = 1'b0;
   logic        mode_single_chip = 1'b0, mode_rom_enable = 1'b1, mode_cs0_wide = 1'b0;
   logic        mode_bus_width = 1'b0, mode_pkg_large = 1'b0, rd_d = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata, exp_q[$];
   logic [20:0] gpio_out = '0, gpio_oe = '0, bus_dout = '0, ext_lvl = '0;
   logic [20:0] pad_in, pad_out, pad_oe, gpio_din, bus_din;
   logic [4:0]  ext_int_req_n;
   int          error_cnt = 0, n_checks = 0;
   always #12.5 core_clk = ~core_clk;
   pdf_top i_dut (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .mode_single_chip, .mode_rom_enable, .mode_cs0_wide, .mode_bus_width, .mode_pkg_large,
      .pad_in, .pad_out, .pad_oe, .gpio_out, .gpio_oe, .gpio_din, .bus_dout, .bus_doe,
      .bus_din, .ext_int_req_n);
   pdf_far_model i_far (.pad_out, .pad_oe, .ext_lvl, .pad_in);
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // one bus cycle; a read notes its expected data
   task bus(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d,
            input logic [15:0] e);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
      if (r)
         exp_q.push_back(e);
      @(posedge core_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge core_clk)
   begin
      rd_d <= reg_rd;
      if (rd_d)
         chk(reg_rdata, exp_q.pop_front());
   end
   initial
   begin
      #500000;
      error_cnt++;
      $display("MISMATCH t=%0t watchdog", $time);
      test_done;
   end
   initial
   begin
      logic [15:0] v;
      logic [20:0] eo, ed, sel, pv;
      logic [4:0]  ei, hi_irq;
      logic [1:0]  code;
      logic [2:0]  m;
      logic        b;
      void'($urandom(96452));
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      bus(0, 1, 8'h04, 0, 16'h0000);
      bus(0, 1, 8'h00, 0, 16'h0000);
      bus(0, 1, 8'h3c, 0, 16'h0000);
      $display("test reset values done");
      for (int k = 0; k < 24; k++)
      begin
         v = $urandom;
         code = k[1:0];
         m = k / 4;
         mode_single_chip <= m == 3'd5;
         mode_rom_enable <= m[0];
         mode_cs0_wide <= m[1];
         {mode_bus_width, mode_pkg_large, bus_doe} <= $urandom;
         gpio_out <= $urandom;
         gpio_oe <= $urandom;
         bus_dout <= $urandom;
         ext_lvl <= $urandom;
         bus(1, 0, 8'h00, {~v[5:0], {5{code}}}, 0);
         bus(1, 0, 8'h04, v, 0);
         bus(0, 1, 8'h04, 0, v);
         bus(0, 1, 8'h00, 0, {6'h00, {5{code}}});
         bus(0, 0, 8'h00, 0, 0);
         repeat (4) @(posedge core_clk);
         #1;
         for (int n = 0; n < 16; n++)
         begin
            b = mode_single_chip ? 1'b0 : (!mode_rom_enable ? 1'b1 : v[n]);
            sel[n] = b;
            eo[n] = b ? bus_doe : gpio_oe[n];
            ed[n] = b ? bus_dout[n] : gpio_out[n];
         end
         for (int i = 0; i < 5; i++)
         begin
            b = code == 2'b01 ? !mode_single_chip : (code == 2'b00 && !mode_single_chip
               && !mode_rom_enable && mode_cs0_wide);
            sel[16+i] = b;
            hi_irq[i] = code == 2'b10;
            eo[16+i] = code == 2'b10 ? 1'b0 : (b ? bus_doe : gpio_oe[16+i]);
            ed[16+i] = b ? bus_dout[16+i] : gpio_out[16+i];
            ei[i] = code == 2'b10 ? ext_lvl[16+i] : 1'b1;
         end
         // pad level as the far side sees it with the expected drive
         pv = (eo & ed) | (~eo & ext_lvl);
         chk(pad_oe, eo);
         chk(pad_out, ed);
         chk(ext_int_req_n, ei);
         chk(gpio_din, pv);
         chk(bus_din, pv & sel);
         @(posedge core_clk);
         bus(0, 1, 8'h08, 0, sel[15:0]);
         bus(0, 1, 8'h0c, 0, {3'h0, hi_irq, 3'h0, sel[20:16]});
         bus(0, 1, 8'h10, 0, {11'h000, mode_pkg_large, mode_bus_width,
            mode_cs0_wide, mode_rom_enable, mode_single_chip});
      end
      $display("test function select done");
      bus(0, 1, 8'h04, 0, v);
      bus(0, 0, 8'h00, 0, 0);
      rst_n <= 1'b0;
      @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      bus(0, 1, 8'h04, 0, 16'h0000);
      bus(0, 1, 8'h00, 0, 16'h0000);
      bus(0, 0, 8'h00, 0, 0);
      repeat (2) @(posedge core_clk);
      $display("test power-on reset done");
      test_done;
   end
endmodule // port_d_pin_function_select_tb_top
`default_nettype wire
